/* tmrb_timer.sv */
// reloadable 8-bit up timer with ahb-lite register slave
// assumes one clock hclk, async active-low reset, single word transfers
//
// How it works
// - mode bit 7 selects interval (0) or auto-reload (1) operation.
// - mode bits 6 to 3 always read one; writes to them ignored.
// - select codes 0-6 pick phi/8192..phi/8; code 7 picks event pin.
// - external edge polarity comes from a separate edge-select bit.
// - counter is readable anytime; software writes to its address load it directly.
// - counting past 0xFF sets the overflow request flag.
// - one address: reads return count, writes go to reload register.
// - reset clears both counter and reload register to zero.
// - writing reload also loads the counter at the same moment.
// - auto-reload mode loads reload value into counter on overflow.
// - interval mode wraps counter to zero on overflow, keeps counting.
// - after reset counting starts at once in interval mode, default clock.
// - overflow interrupts the processor only while its enable bit is one.
// - external counting only with select all ones, once per selected edge.
`timescale 1ns/10ps
`default_nettype none

module tmrb_timer
	import tmrb_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic event_input_pin,
	output logic irq
);

	// bus slave state
	tmrb_bus_t bus_q;
	tmrb_bus_t bus_d;
	logic wr_q;
	logic [17:0] addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	// timer state
	logic mode_q;
	logic [2:0] sel_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] rld_q;
	logic stat_q;
	logic stat_d;
	logic mask_q;
	logic edge_q;
	logic irq_q;
	logic [TMRB_PRE_W-1:0] presc_q;
	logic ev_s1_q;
	logic ev_s2_q;
	logic ev_s3_q;

	// address phase decode
	wire accept = hsel & hready & (htrans == TMRB_HTRANS_NONSEQ);
	wire word_ok = hsize == TMRB_HSIZE_WORD;
	wire acc_wr = accept & hwrite & word_ok;
	wire acc_rd = accept & ~hwrite;

	// data phase decode
	wire hit_mode = addr_q == TMRB_ADDR_MODE;
	wire hit_count = addr_q == TMRB_ADDR_COUNT;
	wire hit_stat = addr_q == TMRB_ADDR_IRQ_STAT;
	wire hit_mask = addr_q == TMRB_ADDR_IRQ_MASK;
	wire hit_evt = addr_q == TMRB_ADDR_EVT_CTRL;
	wire [7:0] wbyte = hwdata[TMRB_DW-1:0];
	wire mode_wr = wr_q & hit_mode;
	wire reload_wr = wr_q & hit_count;
	wire stat_clr = wr_q & hit_stat & wbyte[TMRB_OVF_BIT];
	wire mask_wr = wr_q & hit_mask;
	wire evt_wr = wr_q & hit_evt;

	// read mux, sampled one cycle after the address phase
	wire [7:0] mode_rd = {mode_q, TMRB_MODE_RSVD, sel_q};
	wire [31:0] rd_mux =
		hit_mode ? {24'h00_0000, mode_rd} :
		hit_count ? {24'h00_0000, cnt_q} :
		hit_stat ? {31'h0000_0000, stat_q} :
		hit_mask ? {31'h0000_0000, mask_q} :
		hit_evt ? {31'h0000_0000, edge_q} :
		TMRB_RD_ZERO;

	always_comb begin
		bus_d = bus_q;
		if (acc_rd) begin
			bus_d = TMRB_BUS_RDATA;
		end else if (bus_q == TMRB_BUS_RDATA) begin
			bus_d = TMRB_BUS_IDLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q <= TMRB_BUS_IDLE;
			wr_q <= 1'b0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else if (ce) begin
			bus_q <= bus_d;
			wr_q <= acc_wr;
			hreadyout_q <= ~acc_rd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= '0;
		end else if (ce && accept) begin
			addr_q <= haddr[TMRB_AW-1:0];
		end
	end

	// read data captured in the wait cycle of a read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= TMRB_RD_ZERO;
		end else if (ce && bus_q == TMRB_BUS_RDATA) begin
			hrdata_q <= rd_mux;
		end
	end

	// prescaler taps as one-cycle enables
	logic [TMRB_NTAP:0] tick;
	genvar gi;
	assign tick[TMRB_NTAP] = 1'b0;
	generate
		for (gi = 0; gi < TMRB_NTAP; gi = gi + 1) begin : g_tap
			localparam int TB = TMRB_TAP_BITS[gi];
			assign tick[gi] = &presc_q[TB-1:0];
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_q <= '0;
		end else if (ce) begin
			presc_q <= presc_q + TMRB_PRE_W'(1);
		end
	end

	// event pin: two-flop synchroniser then edge detect
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_s1_q <= 1'b0;
			ev_s2_q <= 1'b0;
			ev_s3_q <= 1'b0;
		end else if (ce) begin
			ev_s1_q <= event_input_pin;
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end

	wire ev_rise = ev_s2_q & ~ev_s3_q;
	wire ev_fall = ~ev_s2_q & ev_s3_q;
	wire ev_edge = edge_q ? ev_rise : ev_fall;
	wire sel_ext = sel_q == TMRB_SEL_EXT;
	wire cnt_en = sel_ext ? ev_edge : tick[sel_q];
	wire at_max = cnt_q == TMRB_CNT_MAX;
	wire ovf = cnt_en & at_max & ~reload_wr;

	always_comb begin
		cnt_d = cnt_q;
		if (reload_wr) begin
			cnt_d = wbyte;
		end else if (cnt_en) begin
			if (at_max) begin
				cnt_d = mode_q ? rld_q : TMRB_CNT_RST;
			end else begin
				cnt_d = cnt_q + TMRB_CNT_ONE;
			end
		end
	end

	// hardware set wins over a same-cycle software clear
	always_comb begin
		stat_d = stat_q;
		if (stat_clr) begin
			stat_d = 1'b0;
		end
		if (ovf) begin
			stat_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= 1'b0;
			sel_q <= TMRB_SEL_RST;
		end else if (ce && mode_wr) begin
			mode_q <= wbyte[TMRB_MODE_BIT];
			sel_q <= wbyte[TMRB_SEL_HI:TMRB_SEL_LO];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rld_q <= TMRB_RLD_RST;
		end else if (ce && reload_wr) begin
			rld_q <= wbyte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= TMRB_CNT_RST;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_q <= 1'b0;
		end else if (ce) begin
			stat_q <= stat_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= 1'b0;
		end else if (ce && mask_wr) begin
			mask_q <= wbyte[TMRB_OVF_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_q <= 1'b0;
		end else if (ce && evt_wr) begin
			edge_q <= wbyte[TMRB_EDGE_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= stat_d & mask_q;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign irq = irq_q;

	// checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_reload_load: assert property (
		ce && reload_wr |=> cnt_q == $past(wbyte) && rld_q == $past(wbyte))
		else $error("reload write did not load counter and reload");

	a_interval_wrap: assert property (
		ce && ovf && !mode_q |=> cnt_q == TMRB_CNT_RST)
		else $error("interval overflow did not wrap to zero");

	a_auto_reload: assert property (
		ce && ovf && mode_q |=> cnt_q == $past(rld_q))
		else $error("auto-reload overflow did not load reload value");

	a_ovf_flag: assert property (
		ce && ovf |=> stat_q)
		else $error("overflow did not set request flag");

	a_count_step: assert property (
		ce && cnt_en && !reload_wr && !at_max
		|=> cnt_q == $past(cnt_q) + TMRB_CNT_ONE)
		else $error("counter did not step by one");

	a_count_hold: assert property (
		!(ce && (cnt_en || reload_wr)) |=> $stable(cnt_q))
		else $error("counter moved without an enable");

	a_ext_edge: assert property (
		ce && sel_ext && edge_q && ev_s2_q && !ev_s3_q && !reload_wr
		&& !at_max |=> cnt_q == $past(cnt_q) + TMRB_CNT_ONE)
		else $error("selected pin edge did not count");

	a_mode_rsvd: assert property (
		ce && bus_q == TMRB_BUS_RDATA && hit_mode
		|=> hrdata_q[TMRB_RSVD_HI:TMRB_RSVD_LO] == TMRB_MODE_RSVD)
		else $error("reserved mode bits not read as ones");

	a_irq_gate: assert property (
		ce && !mask_q && !mask_wr |=> !irq_q)
		else $error("interrupt raised while disabled");

	a_read_wait: assert property (
		ce && acc_rd |=> !hreadyout_q ##1 (hreadyout_q || !$past(ce)))
		else $error("read answer not after one wait state");

	a_mode_write: assert property (
		ce && mode_wr |=> mode_q == $past(wbyte[TMRB_MODE_BIT]))
		else $error("mode bit write not taken");

	a_sel_write: assert property (
		ce && mode_wr
		|=> sel_q == $past(wbyte[TMRB_SEL_HI:TMRB_SEL_LO]))
		else $error("clock select write not taken");

	a_tap_pulse: assert property (
		ce && !sel_ext && cnt_en && !mode_wr |=> !cnt_en)
		else $error("prescaler enable longer than one cycle");

	a_edge_pulse: assert property (
		ce && sel_ext && cnt_en && !evt_wr && !mode_wr |=> !cnt_en)
		else $error("pin edge enable longer than one cycle");

	a_ce_freeze: assert property (
		!ce |=> $stable(cnt_q) && $stable(presc_q) && $stable(stat_q))
		else $error("state moved while clock enable low");

	a_rld_hold: assert property (
		!(ce && reload_wr) |=> $stable(rld_q))
		else $error("reload register changed without a write");

	a_count_read: assert property (
		ce && bus_q == TMRB_BUS_RDATA && hit_count
		|=> hrdata_q[TMRB_DW-1:0] == $past(cnt_q))
		else $error("count address did not read the counter");

	a_irq_level: assert property (
		ce && stat_q && mask_q && !stat_clr && !mask_wr |=> irq_q)
		else $error("unmasked overflow flag gave no interrupt");

	a_flag_clear: assert property (
		ce && stat_clr && !ovf |=> !stat_q)
		else $error("write one did not clear overflow flag");

	a_flag_hold: assert property (
		ce && !stat_q && !ovf |=> !stat_q)
		else $error("overflow flag set without an overflow");

	a_write_nowait: assert property (
		ce && acc_wr |=> hreadyout_q)
		else $error("write inserted a wait state");

	a_ext_only: assert property (
		ce && sel_ext && !ev_edge && !reload_wr |=> $stable(cnt_q))
		else $error("counter moved in event mode without a pin edge");

	a_fall_edge: assert property (
		ce && sel_ext && !edge_q && !ev_s2_q && ev_s3_q && !reload_wr
		&& !at_max |=> cnt_q == $past(cnt_q) + TMRB_CNT_ONE)
		else $error("falling pin edge did not count");

	a_rise_only: assert property (
		ce && sel_ext && edge_q && !ev_s2_q && !reload_wr
		|=> $stable(cnt_q))
		else $error("falling pin edge counted while rising selected");

	a_irq_no_flag: assert property (
		ce && !stat_q && !ovf |=> !irq_q)
		else $error("interrupt raised without overflow flag");

	c_auto_ovf: cover property (ce && ovf && mode_q);
	c_ext_count: cover property (ce && sel_ext && cnt_en);
	c_irq_rise: cover property (!irq_q ##1 irq_q);
	c_set_clear: cover property (ce && ovf && stat_clr);
	c_ce_stall: cover property (!ce ##1 ce);

endmodule

`default_nettype wire

/* tmrb_pkg.sv */
// constants, register map and types for the reloadable 8-bit up timer
// assumes a single 50 MHz system clock that is also the prescaler input
`default_nettype none

package tmrb_pkg;

	localparam int TMRB_DW = 8;
	localparam int TMRB_AW = 18;

	// register indices; byte address is four times the index
	localparam logic [15:0] TMRB_IDX_MODE = 16'hFFC2;
	localparam logic [15:0] TMRB_IDX_COUNT = 16'hFFC3;
	localparam logic [15:0] TMRB_IDX_IRQ_STAT = 16'hFFD0;
	localparam logic [15:0] TMRB_IDX_IRQ_MASK = 16'hFFD1;
	localparam logic [15:0] TMRB_IDX_EVT_CTRL = 16'hFFD2;

	localparam logic [17:0] TMRB_ADDR_MODE = {TMRB_IDX_MODE, 2'h0};
	localparam logic [17:0] TMRB_ADDR_COUNT = {TMRB_IDX_COUNT, 2'h0};
	localparam logic [17:0] TMRB_ADDR_IRQ_STAT = {TMRB_IDX_IRQ_STAT, 2'h0};
	localparam logic [17:0] TMRB_ADDR_IRQ_MASK = {TMRB_IDX_IRQ_MASK, 2'h0};
	localparam logic [17:0] TMRB_ADDR_EVT_CTRL = {TMRB_IDX_EVT_CTRL, 2'h0};

	// field positions
	localparam int TMRB_MODE_BIT = 7;
	localparam int TMRB_RSVD_HI = 6;
	localparam int TMRB_RSVD_LO = 3;
	localparam int TMRB_SEL_HI = 2;
	localparam int TMRB_SEL_LO = 0;
	localparam int TMRB_OVF_BIT = 0;
	localparam int TMRB_EDGE_BIT = 0;

	// reset and fixed values
	localparam logic [3:0] TMRB_MODE_RSVD = 4'hF;
	localparam logic [2:0] TMRB_SEL_RST = 3'h0;
	localparam logic [2:0] TMRB_SEL_EXT = 3'h7;
	localparam logic [7:0] TMRB_CNT_RST = 8'h00;
	localparam logic [7:0] TMRB_RLD_RST = 8'h00;
	localparam logic [7:0] TMRB_CNT_MAX = 8'hFF;
	localparam logic [7:0] TMRB_CNT_ONE = 8'h01;
	localparam logic [31:0] TMRB_RD_ZERO = 32'h0000_0000;

	// ahb encodings
	localparam logic [1:0] TMRB_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] TMRB_HSIZE_WORD = 3'h2;

	// prescaler: tap i divides the system clock by 2**TMRB_TAP_BITS[i]
	localparam int TMRB_PRE_W = 13;
	localparam int TMRB_NTAP = 7;
	localparam int TMRB_TAP_BITS [0:6] = '{13, 11, 9, 8, 7, 5, 3};

	typedef enum logic {
		TMRB_BUS_IDLE = 1'b0,
		TMRB_BUS_RDATA = 1'b1
	} tmrb_bus_t;

endpackage

`default_nettype wire

/* tmrb_evt_src.sv */
// external event source model for the timer's event pin
// assumes the caller starts pulses just after a rising hclk edge
`timescale 1ns/10ps
`default_nettype none

module tmrb_evt_src (
	input wire logic hclk,
	output logic event_input_pin
);
	initial event_input_pin = 1'b0;

	// each pulse is 4 cycles high then 4 low, beyond the sync minimum
	task automatic pulses(input int n);
		repeat (n) begin
			event_input_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			event_input_pin <= 1'b0;
			repeat (4) @(posedge hclk);
		end
	endtask
endmodule

`default_nettype wire

/* tb_top.sv */
// self-checking bench for the reloadable 8-bit up timer
// assumes one 50 MHz clock; hready is looped back from hreadyout
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import tmrb_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = TMRB_HSIZE_WORD;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	wire event_input_pin;
	int err_total = 0;
	int n_compared = 0;
	logic [31:0] rd;

	always #10 hclk = ~hclk;

	tmrb_timer u_tmrb_timer (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.event_input_pin(event_input_pin), .irq(irq));
	tmrb_evt_src u_tmrb_evt_src (.hclk(hclk),
		.event_input_pin(event_input_pin));

	task automatic wait_rdy;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask

	task automatic bus(input logic w, input logic [17:0] a,
		input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {14'h0, a};
		hwrite <= w;
		htrans <= TMRB_HTRANS_NONSEQ;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input string nm, input logic [17:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, e, rd);
	endtask

	task automatic rng(input string nm, input int lo, input int hi);
		n_compared++;
		if (^rd === 1'bx || rd < lo || rd > hi) begin
			err_total++;
			$display("ERROR %s expected %0d..%0d seen %h", nm, lo, hi, rd);
		end
	endtask

	task automatic t_reset;
		rchk("mode", TMRB_ADDR_MODE, 32'h0000_0078);
		rchk("count", TMRB_ADDR_COUNT, 32'h0000_0000);
		chk("irq", 32'h0, {31'h0, irq});
		repeat (16384) @(posedge hclk);
		bus(1'b0, TMRB_ADDR_COUNT, 8'h00);
		rng("count run", 1, 3);
	endtask

	task automatic t_mode;
		bus(1'b1, TMRB_ADDR_MODE, 8'h05);
		rchk("mode", TMRB_ADDR_MODE, 32'h0000_007D);
		bus(1'b1, TMRB_ADDR_MODE, 8'h80);
		rchk("mode", TMRB_ADDR_MODE, 32'h0000_00F8);
		bus(1'b1, 18'h00100, 8'h5A);
		rchk("unmapped", 18'h00100, 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic t_ext;
		bus(1'b1, TMRB_ADDR_MODE, 8'h07);
		bus(1'b1, TMRB_ADDR_EVT_CTRL, 8'h00);
		bus(1'b1, TMRB_ADDR_COUNT, 8'hFD);
		repeat (40) @(posedge hclk);
		rchk("count", TMRB_ADDR_COUNT, 32'h0000_00FD);
		u_tmrb_evt_src.pulses(3);
		repeat (4) @(posedge hclk);
		rchk("count", TMRB_ADDR_COUNT, 32'h0000_0000);
		rchk("status", TMRB_ADDR_IRQ_STAT, 32'h0000_0001);
		bus(1'b1, TMRB_ADDR_EVT_CTRL, 8'h01);
		u_tmrb_evt_src.pulses(1);
		repeat (4) @(posedge hclk);
		rchk("count", TMRB_ADDR_COUNT, 32'h0000_0001);
	endtask

	task automatic t_irq;
		bus(1'b1, TMRB_ADDR_IRQ_MASK, 8'h01);
		repeat (2) @(posedge hclk);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, TMRB_ADDR_IRQ_MASK, 8'h00);
		repeat (2) @(posedge hclk);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, TMRB_ADDR_IRQ_STAT, 8'h01);
		rchk("status", TMRB_ADDR_IRQ_STAT, 32'h0);
	endtask

	task automatic t_reload;
		bus(1'b1, TMRB_ADDR_MODE, 8'h87);
		bus(1'b1, TMRB_ADDR_COUNT, 8'hFE);
		u_tmrb_evt_src.pulses(2);
		repeat (4) @(posedge hclk);
		rchk("count", TMRB_ADDR_COUNT, 32'h0000_00FE);
		rchk("status", TMRB_ADDR_IRQ_STAT, 32'h0000_0001);
	endtask

	task automatic t_taps;
		for (int c = 0; c < TMRB_NTAP; c++) begin
			bus(1'b1, TMRB_ADDR_MODE, 8'(c));
			bus(1'b1, TMRB_ADDR_COUNT, 8'h00);
			repeat (3 << TMRB_TAP_BITS[c]) @(posedge hclk);
			bus(1'b0, TMRB_ADDR_COUNT, 8'h00);
			rng("tap count", 2, 4);
		end
	endtask

	task automatic t_freeze;
		bus(1'b1, TMRB_ADDR_MODE, 8'h07);
		bus(1'b1, TMRB_ADDR_COUNT, 8'h10);
		ce <= 1'b0;
		u_tmrb_evt_src.pulses(2);
		ce <= 1'b1;
		repeat (8) @(posedge hclk);
		rchk("count frozen", TMRB_ADDR_COUNT, 32'h0000_0010);
		u_tmrb_evt_src.pulses(1);
		repeat (4) @(posedge hclk);
		rchk("count", TMRB_ADDR_COUNT, 32'h0000_0011);
	endtask

	task automatic t_rst2;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("count", TMRB_ADDR_COUNT, 32'h0000_0000);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, TMRB_ADDR_MODE, 8'h87);
		u_tmrb_evt_src.pulses(256);
		repeat (4) @(posedge hclk);
		rchk("reload zero", TMRB_ADDR_COUNT, 32'h0000_0000);
		rchk("status", TMRB_ADDR_IRQ_STAT, 32'h0000_0001);
	endtask

	task automatic finish_test;
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_mode();
		t_ext();
		t_irq();
		t_reload();
		t_freeze();
		t_rst2();
		t_taps();
		finish_test();
	end

	initial begin
		repeat (80000) @(posedge hclk);
		err_total++;
		finish_test();
	end
endmodule

`default_nettype wire
